// ---- src/tws_regs.svh ----
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
// fixed upper nibble of the device address word
`define TWS_DEV_CODE   4'hA
`define TWS_BYTE_BITS  8
`define TWS_PAGE_BITS  5
`define TWS_ADDR_BITS  13
// programming_cycle_time in ms, and the system clock in Hz
`define TWS_TWR_MS     5
`define TWS_CLK_HZ     100000000
`define TWS_PROG_CYC   (`TWS_TWR_MS * (`TWS_CLK_HZ / 1000))
`endif

// ---- src/tws_pkg.sv ----
package tws_pkg;
  typedef enum logic [2:0] {
    TWS_IDLE = 3'h0,
    TWS_DEV  = 3'h1,
    TWS_AHI  = 3'h2,
    TWS_ALO  = 3'h3,
    TWS_WDAT = 3'h4,
    TWS_RD   = 3'h5
  } tws_state_t;
endpackage : tws_pkg

// ---- src/tws_eeprom.sv ----
`include "tws_regs.svh"

// Operation
// [RULE1] data changes only while clock low
// [RULE2] data fall with clock high starts
// [RULE3] data rise with clock high stops
// [RULE4] eight-bit words, acknowledge on ninth clock
// [RULE5] standby at power-up and after stop
// [RULE6] master recovers with nine clocks, start
// [RULE7] address word opens with fixed nibble
// [RULE8] three select bits match strap pins
// [RULE9] last address bit selects read/write
// [RULE10] match acknowledges, mismatch releases to standby
// [RULE11] write-inhibit pin blocks array changes
// [RULE12] byte write: address, two words, data
// [RULE13] stop after write starts timed programming
// [RULE14] page write up to 32 bytes
// [RULE15] write increments low five bits only
// [RULE16] busy device ignores its address
// [RULE17] counter keeps last location plus one
// [RULE18] reads wrap across whole array
// [RULE19] current-address read from counter
// [RULE20] random read via dummy write, restart
// [RULE21] master ack continues sequential read
// [RULE22] small variant ignores top address bit
// [RULE23] sample on rise, drive after fall
// [RULE24] 32-byte pages, 12/13-bit address
// [RULE25] inhibited writes ack but never program
module tws_eeprom
  import tws_pkg::*;
#(
  parameter int ADDR_W      = `TWS_ADDR_BITS,
  parameter int PROG_CYCLES = `TWS_PROG_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic en,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  input  wire logic chip_select_bit0,
  input  wire logic chip_select_bit1,
  input  wire logic chip_select_bit2,
  input  wire logic write_inhibit,
  output logic      prog_busy
);

  localparam int PB = `TWS_PAGE_BITS;

  logic [1:0]  rst_sync_q;
  logic        rst_sync_n;
  logic [5:0]  meta_q;
  logic [5:0]  sync_q;
  logic        scl_p_q;
  logic        sda_p_q;
  logic        scl_s;
  logic        sda_s;
  logic [2:0]  csel_s;
  logic        wp_s;
  logic        rise_ev;
  logic        fall_ev;
  logic        start_ev;
  logic        stop_ev;

  tws_state_t  state_q;
  tws_state_t  state_d;
  tws_state_t  nxt_q;
  tws_state_t  nxt_d;
  logic [3:0]  bit_q;
  logic [3:0]  bit_d;
  logic [7:0]  shift_q;
  logic [7:0]  shift_d;
  logic [7:0]  tx_q;
  logic [7:0]  tx_d;
  logic [7:0]  hi_q;
  logic [7:0]  hi_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic        oe_q;
  logic        oe_d;
  logic        ack_q;
  logic        ack_d;
  logic        wrote_q;
  logic        wrote_d;
  logic        busy_q;
  logic        busy_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0]  mem [0:(1<<ADDR_W)-1];

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_q[1];

  // pins cross into clk domain; logic reads sync_q and its delayed copies scl_p_q and sda_p_q, never meta_q
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      meta_q  <= 6'h03;
      sync_q  <= 6'h03;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (en) begin
      meta_q  <= {write_inhibit, chip_select_bit2, chip_select_bit1,
                  chip_select_bit0, sda_i, scl_i};
      sync_q  <= meta_q;
      scl_p_q <= sync_q[0];
      sda_p_q <= sync_q[1];
    end
  end

  assign scl_s   = sync_q[0];
  assign sda_s   = sync_q[1];
  assign csel_s  = sync_q[4:2];
  assign wp_s    = sync_q[5];
  assign rise_ev = en && scl_s && !scl_p_q;
  assign fall_ev = en && !scl_s && scl_p_q;
  // a data edge with the clock high both samples is a condition, not data
  assign start_ev = en && scl_s && scl_p_q && sda_p_q && !sda_s; // [RULE1] [RULE2]
  assign stop_ev  = en && scl_s && scl_p_q && !sda_p_q && sda_s; // [RULE1] [RULE3]

  always_comb begin
    logic       load;
    logic [3:0] idx;
    load    = 1'b0;
    idx     = 4'h7 - bit_q;
    state_d = state_q;
    nxt_d   = nxt_q;
    bit_d   = bit_q;
    shift_d = shift_q;
    tx_d    = tx_q;
    hi_d    = hi_q;
    addr_d  = addr_q; // [RULE17]
    oe_d    = oe_q;
    ack_d   = ack_q;
    wrote_d = wrote_q;
    mem_we  = 1'b0;
    mem_wa  = addr_q;
    if (start_ev) begin
      // also ends the master's recovery sequence from any state
      state_d = TWS_DEV; // [RULE2] [RULE6]
      bit_d   = 4'h0;
      ack_d   = 1'b0;
      oe_d    = 1'b0;
      wrote_d = 1'b0;
    end else if (stop_ev) begin
      state_d = TWS_IDLE; // [RULE3] [RULE5]
      ack_d   = 1'b0;
      oe_d    = 1'b0;
    end else if (state_q == TWS_RD) begin
      if (rise_ev && bit_q == 4'h8) begin
        // master's answer sampled on the ninth rise
        state_d = sda_s ? TWS_IDLE : TWS_RD; // [RULE21] [RULE23]
        bit_d   = 4'h9;
      end else if (rise_ev && bit_q < 4'h8) begin
        bit_d = bit_q + 4'h1;
      end else if (fall_ev && bit_q == 4'h9) begin
        load = 1'b1; // [RULE21]
      end else if (fall_ev && bit_q == 4'h8) begin
        oe_d = 1'b0;
      end else if (fall_ev && bit_q != 4'h0) begin
        oe_d = ~tx_q[idx[2:0]]; // [RULE23]
      end
    end else if (state_q != TWS_IDLE) begin
      if (rise_ev && bit_q < 4'h8) begin
        shift_d = {shift_q[6:0], sda_s}; // [RULE4] [RULE23]
        bit_d   = bit_q + 4'h1;
      end else if (fall_ev && bit_q == 4'h8 && ack_q) begin
        ack_d   = 1'b0;
        oe_d    = 1'b0;
        bit_d   = 4'h0;
        state_d = nxt_q;
        load    = (nxt_q == TWS_RD); // [RULE19]
      end else if (fall_ev && bit_q == 4'h8) begin
        ack_d = 1'b1; // [RULE4]
        oe_d  = 1'b1;
        case (state_q)
          TWS_DEV: begin
            if (shift_q[7:4] == `TWS_DEV_CODE && shift_q[3:1] == csel_s
                && !busy_q) begin // [RULE7] [RULE8] [RULE16]
              nxt_d = shift_q[0] ? TWS_RD : TWS_AHI; // [RULE9]
            end else begin
              ack_d   = 1'b0; // [RULE10]
              oe_d    = 1'b0;
              state_d = TWS_IDLE;
            end
          end
          TWS_AHI: begin
            hi_d  = shift_q;
            nxt_d = TWS_ALO; // [RULE12]
          end
          TWS_ALO: begin
            // bits above ADDR_W are don't-care
            addr_d = ADDR_W'({hi_q, shift_q}); // [RULE22] [RULE24] [RULE20]
            nxt_d  = TWS_WDAT;
          end
          TWS_WDAT: begin
            mem_we  = !wp_s; // [RULE11] [RULE25]
            wrote_d = wrote_q || !wp_s; // [RULE25]
            addr_d  = {addr_q[ADDR_W-1:PB], addr_q[PB-1:0] + 5'h01}; // [RULE15] [RULE14]
            nxt_d   = TWS_WDAT; // [RULE14]
          end
          default: begin
            ack_d   = 1'b0;
            oe_d    = 1'b0;
            state_d = TWS_IDLE;
          end
        endcase
      end
    end
    if (load) begin
      tx_d   = mem[addr_q];
      oe_d   = ~mem[addr_q][7];
      addr_d = addr_q + 1'b1; // [RULE17] [RULE18]
      bit_d  = 4'h0;
    end
  end

  // programming timer; counts per clk, not per bus clock
  always_comb begin
    busy_d = busy_q;
    cnt_d  = cnt_q;
    if (busy_q && en) begin
      cnt_d  = cnt_q - 32'h1;
      busy_d = (cnt_q != 32'h1); // [RULE5]
    end else if (stop_ev && state_q == TWS_WDAT && wrote_q) begin
      busy_d = 1'b1; // [RULE13]
      cnt_d  = 32'(PROG_CYCLES);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q   <= TWS_IDLE; // [RULE5]
      nxt_q     <= TWS_IDLE;
      bit_q     <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      hi_q      <= 8'h00;
      addr_q    <= '0;
      oe_q      <= 1'b0;
      ack_q     <= 1'b0;
      wrote_q   <= 1'b0;
      busy_q    <= 1'b0;
      cnt_q     <= 32'h0;
      sda_o     <= 1'b0;
      sda_oe    <= 1'b0;
      prog_busy <= 1'b0;
    end else if (en) begin
      state_q   <= state_d;
      nxt_q     <= nxt_d;
      bit_q     <= bit_d;
      shift_q   <= shift_d;
      tx_q      <= tx_d;
      hi_q      <= hi_d;
      addr_q    <= addr_d;
      oe_q      <= oe_d;
      ack_q     <= ack_d;
      wrote_q   <= wrote_d;
      busy_q    <= busy_d;
      cnt_q     <= cnt_d;
      sda_o     <= 1'b0;
      sda_oe    <= oe_d;
      prog_busy <= busy_d;
    end
  end

  // array contents are not reset: they stand in for nonvolatile cells
  always_ff @(posedge clk) begin
    if (en && mem_we) begin
      mem[mem_wa] <= shift_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  a_start_to_addr: assert property (start_ev |=> state_q == TWS_DEV && bit_q == 4'h0) // [RULE2]
    else $error("start did not open address phase");
  a_stop_to_idle: assert property (stop_ev |=> state_q == TWS_IDLE && !sda_oe) // [RULE3]
    else $error("stop did not return to standby");
  a_ack_drives_low: assert property (ack_q |-> oe_q && bit_q == 4'h8) // [RULE4]
    else $error("acknowledge not driven in ninth clock");
  a_busy_no_ack: assert property (busy_q && state_q == TWS_DEV |-> !ack_d) // [RULE16]
    else $error("acknowledged address while programming");
  a_match_needed: assert property (state_q == TWS_DEV && ack_d && !ack_q // [RULE8]
      |-> shift_q[3:1] == csel_s && shift_q[7:4] == `TWS_DEV_CODE)
    else $error("acknowledged a foreign device address");
  a_inhibit_write: assert property (mem_we |-> !wp_s && state_q == TWS_WDAT && fall_ev) // [RULE11]
    else $error("array written while inhibited");
  a_page_fixed: assert property (mem_we // [RULE15]
      |=> addr_q[ADDR_W-1:PB] == $past(addr_q[ADDR_W-1:PB])
      && addr_q[PB-1:0] == $past(addr_q[PB-1:0]) + 5'h01)
    else $error("write address left its page");
  a_busy_holds: assert property ($rose(busy_q) |-> busy_q[*8]) // [RULE13]
    else $error("programming cycle ended early");
  a_oe_after_fall: assert property ($rose(oe_q) |-> $past(fall_ev)) // [RULE23]
    else $error("data line driven away from a clock fall");
  a_read_inc: assert property (state_q == TWS_RD && fall_ev && bit_q == 4'h9 // [RULE18]
      |=> addr_q == $past(addr_q) + 1'b1)
    else $error("read did not advance the counter");

  c_write_prog: cover property ($rose(busy_q));
  c_read_byte: cover property (state_q == TWS_RD && rise_ev && bit_q == 4'h8);
  c_busy_poll: cover property (busy_q && state_q == TWS_DEV && fall_ev && bit_q == 4'h8);
  c_seq_read: cover property (state_q == TWS_RD && fall_ev && bit_q == 4'h9);

endmodule : tws_eeprom

// ---- test/tws_master.sv ----
module tws_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  // the bus clock stands high between frames, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic put_bit(input logic b, output logic r);
    sda_pull <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    r = sda;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask : put_bit
  // the longer release lets a device ack end before the clock rises
  task automatic start;
    sda_pull <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask : start
  task automatic stop;
    sda_pull <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b0;
    tick(4);
  endtask : stop
  // seen reports the data line high in the last clock-high window
  task automatic recover(output logic seen);
    logic r;
    seen = 1'b0;
    for (int i = 0; i < 9; i++) begin
      put_bit(1'b1, r);
      seen = r;
    end
  endtask : recover
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r);
    put_bit(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(~ack, r);
  endtask : rd_byte
endmodule : tws_master

// ---- test/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk;
  logic       rst_n;
  logic       en;
  logic       scl;
  logic       sda_pull;
  logic       sda_o;
  logic       sda_oe;
  logic       prog_busy;
  logic [2:0] sel;
  logic       wi;
  wire logic  sda;
  int         num_errors;
  int         n_checks;
  int         cyc;
  // open-drain bus with a pull-up: a driver can only pull it low
  assign sda = ~sda_pull & (~sda_oe | sda_o);
  // a short programming time keeps the run small but outlasts one polling header
  tws_eeprom #(.ADDR_W(13), .PROG_CYCLES(200)) i_tws_eeprom (
    .clk              (clk),
    .rst_n            (rst_n),
    .en               (en),
    .scl_i            (scl),
    .sda_i            (sda),
    .sda_o            (sda_o),
    .sda_oe           (sda_oe),
    .chip_select_bit0 (sel[0]),
    .chip_select_bit1 (sel[1]),
    .chip_select_bit2 (sel[2]),
    .write_inhibit    (wi),
    .prog_busy        (prog_busy)
  );
  tws_master i_tws_master (
    .clk      (clk),
    .sda      (sda),
    .scl      (scl),
    .sda_pull (sda_pull)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask : check
  task automatic header(input logic [7:0] d, input logic exp);
    logic a;
    i_tws_master.start();
    i_tws_master.wr_byte(d, a);
    check("address ack", {7'h00, exp}, {7'h00, a});
  endtask : header
  task automatic wr_seq(input logic [15:0] a, input int n, input logic [7:0] d0);
    logic [7:0] b;
    logic       k;
    header({4'hA, sel, 1'b0}, 1'b1);
    for (int i = 0; i < n + 2; i++) begin
      b = (i == 0) ? a[15:8] : (i == 1) ? a[7:0] : d0 + 8'(i - 2);
      i_tws_master.wr_byte(b, k);
      check("byte ack", 8'h01, {7'h00, k});
    end
    i_tws_master.stop();
  endtask : wr_seq
  task automatic rd_seq(input logic [15:0] a, input int n, input logic [7:0] e0, input logic rnd);
    logic [7:0] b;
    logic       k;
    if (rnd) begin
      header({4'hA, sel, 1'b0}, 1'b1);
      i_tws_master.wr_byte(a[15:8], k);
      i_tws_master.wr_byte(a[7:0], k);
    end
    header({4'hA, sel, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_tws_master.rd_byte(i < n - 1, b);
      check("read data", e0 + 8'(i), b);
    end
    i_tws_master.stop();
  endtask : rd_seq
  task automatic wait_prog;
    int w;
    w = 0;
    while (prog_busy !== 1'b0 && w < 400) begin
      @(posedge clk);
      w++;
    end
    check("busy end", 8'h00, {7'h00, prog_busy});
  endtask : wait_prog
  task automatic t_byte_write;
    logic seen;
    i_tws_master.recover(seen);
    check("bus free", 8'h01, {7'h00, seen});
    wr_seq(16'hE123, 1, 8'h5A);
    check("busy", 8'h01, {7'h00, prog_busy});
    header({4'hA, sel, 1'b0}, 1'b0);
    i_tws_master.stop();
    wait_prog();
    rd_seq(16'h0123, 1, 8'h5A, 1'b1);
  endtask : t_byte_write
  task automatic t_page;
    wr_seq(16'h001E, 5, 8'h30);
    wait_prog();
    rd_seq(16'h001E, 2, 8'h30, 1'b1);
    rd_seq(16'h0000, 2, 8'h32, 1'b1);
    rd_seq(16'h0000, 1, 8'h34, 1'b0);
    wr_seq(16'h1FFF, 1, 8'h31);
    wait_prog();
    rd_seq(16'h1FFF, 2, 8'h31, 1'b1);
  endtask : t_page
  // the timer must not run while the clock enable is low
  task automatic t_freeze;
    wr_seq(16'h0040, 1, 8'h77);
    en <= 1'b0;
    repeat (300) @(posedge clk);
    check("frozen busy", 8'h01, {7'h00, prog_busy});
    en <= 1'b1;
    wait_prog();
    rd_seq(16'h0040, 1, 8'h77, 1'b1);
  endtask : t_freeze
  task automatic t_refuse;
    logic [7:0] bad [4];
    bad = '{8'hA8, 8'hA2, 8'hBA, 8'h2A};
    foreach (bad[i]) begin
      header(bad[i], 1'b0);
      i_tws_master.stop();
    end
  endtask : t_refuse
  task automatic t_inhibit;
    wi <= 1'b1;
    wr_seq(16'h0123, 1, 8'hC3);
    check("busy", 8'h00, {7'h00, prog_busy});
    wi <= 1'b0;
    rd_seq(16'h0123, 1, 8'h5A, 1'b1);
  endtask : t_inhibit
  initial begin
    rst_n = 1'b0;
    en = 1'b1;
    sel = 3'b101;
    wi = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_byte_write();
    t_page();
    t_refuse();
    t_inhibit();
    t_freeze();
    end_of_test();
  end
endmodule : tb_top
